// File: hw/gpt_term.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

module gpt_term #(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_eoi,
  output logic             tx_cmd,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eoi,
  input  wire logic        rx_atn,
  output logic             atn_o,
  output logic             atn_oe_n,
  output logic             hs_participate,
  input  wire logic        ppoll_req,
  output logic             ppoll_resp,
  output logic [4:0]       spoll_wait_code,
  output var gpt_pkg::gpt_ctl_t ctl_state
);
  import gpt_pkg::*;

  gpt_state_t                  s;
  gpt_state_t                  next_s;
  logic                        req;
  logic                        wr_commit;
  logic                        tx_push;
  logic                        tx_in_ready;
  logic [`GPT_TXW_WIDTH-1:0]   tx_word;
  logic [`GPT_TXW_WIDTH-1:0]   tx_head;
  logic [31:0]                 wmask;
  logic [31:0]                 cfg_w;
  logic [31:0]                 ctl_w;
  logic [31:0]                 wdat;
  logic                        rx_take;
  logic                        rx_hit;
  logic                        tx_hit;
  logic                        cfg_on;
  logic                        active;

  function automatic logic char_match(input logic [7:0] b, input logic [15:0] cfg);
    if (cfg[`GPT_CFG_FULL_WIDTH]) begin
      char_match = (b == cfg[`GPT_CFG_CHAR_MSB:0]);
    end else begin
      char_match = (b[6:0] == cfg[6:0]);
    end
  endfunction

  assign req       = wb_cyc_i && wb_stb_i;
  // writes commit on the edge at which the master sees ack
  assign wr_commit = req && wb_we_i && s.ack;
  assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat      = wb_dat_i & wmask;
  assign cfg_w     = ({16'h0000, s.cfg} & ~wmask) | wdat;
  assign ctl_w     = ({23'h0, s.spw, 1'b0, s.ist, s.end_flag_en, s.eot} & ~wmask) | wdat;
  assign active    = (s.ctl == GPT_ACTIVE);
  assign cfg_on    = (s.cfg != `GPT_CFG_RESET);
  assign rx_take   = rx_valid && rx_ready;
  // command bytes under ATN never take part in matching
  assign rx_hit    = rx_take && !rx_atn && cfg_on && char_match(rx_data, s.cfg);
  assign tx_hit    = !active && cfg_on && char_match(wdat[7:0], s.cfg);
  assign tx_push   = wr_commit && (wb_adr_i == `GPT_ADR_TXDATA);

  // the byte is sent as written; nothing is ever inserted after it
  always_comb begin
    tx_word = '0;
    tx_word[7:0] = wdat[7:0];
    tx_word[`GPT_TXW_CMD] = active;
    tx_word[`GPT_TXW_EOI] = !active
      && ((s.cfg[`GPT_CFG_WRITE_EOI] && tx_hit)
          || (s.eot && wdat[`GPT_TX_LAST]));
  end

  // two-entry buffer lets a stalled talker path hold off the bus master
  gpt_fifo2 #(
    .W     (`GPT_TXW_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_txbuf (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (tx_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_head)
  );

  assign tx_data         = tx_head[7:0];
  assign tx_eoi          = tx_head[`GPT_TXW_EOI];
  assign tx_cmd          = tx_head[`GPT_TXW_CMD];
  assign wb_dat_o        = s.rdata;
  assign wb_ack_o        = s.ack;
  assign rx_ready        = s.reading;
  assign atn_o           = 1'b0;
  assign atn_oe_n        = !active;
  assign hs_participate  = active || s.shadow;
  assign ppoll_resp      = s.ppoll_resp;
  assign spoll_wait_code = s.spw;
  assign ctl_state       = s.ctl;

  always_comb begin
    next_s = s;
    // a transmit write waits for buffer room before it is acknowledged
    next_s.ack = req && !s.ack
      && !(wb_we_i && (wb_adr_i == `GPT_ADR_TXDATA) && !tx_in_ready);
    if (req && !s.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        `GPT_ADR_CONFIG:  next_s.rdata = {16'h0000, s.cfg};
        `GPT_ADR_CONTROL: next_s.rdata = {23'h0, s.spw, 1'b0, s.ist, s.end_flag_en, s.eot};
        `GPT_ADR_STATUS:  next_s.rdata = {27'h0, s.reading, s.shadow, active,
                                          s.read_done, s.end_seen};
        `GPT_ADR_RXDATA:  next_s.rdata = {23'h0, s.rx_last_eoi, s.rx_last};
        default:          next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_commit) begin
      unique case (wb_adr_i)
        `GPT_ADR_CONFIG: begin
          next_s.cfg = cfg_w[15:0];
        end
        `GPT_ADR_CONTROL: begin
          next_s.eot         = ctl_w[`GPT_CTL_EOT];
          next_s.end_flag_en = ctl_w[`GPT_CTL_END_FLAG];
          next_s.ist         = ctl_w[`GPT_CTL_IST];
          // out-of-range codes leave the previous setting in place
          if (ctl_w[`GPT_CTL_SPW_MSB:`GPT_CTL_SPW_LSB] <= `GPT_SPW_MAX) begin
            next_s.spw = ctl_w[`GPT_CTL_SPW_MSB:`GPT_CTL_SPW_LSB];
          end
        end
        `GPT_ADR_CMD: begin
          if (wdat[`GPT_CMD_TAKE_CTRL]) begin
            next_s.ctl = GPT_ACTIVE;
          end else if (wdat[`GPT_CMD_GO_STANDBY]) begin
            next_s.ctl    = GPT_STANDBY;
            next_s.shadow = wdat[`GPT_CMD_SHADOW];
          end
          if (wdat[`GPT_CMD_START_READ]) begin
            next_s.reading   = 1'b1;
            next_s.read_done = 1'b0;
          end
        end
        `GPT_ADR_STATUS: begin
          if (wdat[`GPT_ST_END]) begin
            next_s.end_seen = 1'b0;
          end
          if (wdat[`GPT_ST_READ_DONE]) begin
            next_s.read_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // bus events below override a clear in the same cycle
    if (rx_take && !rx_atn) begin
      next_s.rx_last     = rx_data;
      next_s.rx_last_eoi = rx_eoi;
      if (rx_eoi || (s.cfg[`GPT_CFG_READ_STOP] && rx_hit)) begin
        next_s.reading   = 1'b0;
        next_s.read_done = 1'b1;
      end
      if (rx_eoi || (s.end_flag_en && s.cfg[`GPT_CFG_READ_STOP] && rx_hit)) begin
        next_s.end_seen = 1'b1;
      end
    end
    next_s.ppoll_resp = ppoll_req && s.ist;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s             <= '0;
      s.cfg         <= `GPT_CFG_RESET;
      s.end_flag_en <= `GPT_END_FLAG_RESET;
      s.spw         <= `GPT_SPW_RESET;
      s.ctl         <= GPT_STANDBY;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // eoi needs a cause: an enabled match or the last-byte mark
  property p_eoi_only_cause;
    tx_push && !(s.cfg[`GPT_CFG_WRITE_EOI] && cfg_on
      && (s.cfg[`GPT_CFG_FULL_WIDTH] ? (wdat[7:0] == s.cfg[7:0]) : (wdat[6:0] == s.cfg[6:0])))
      && !(s.eot && wdat[`GPT_TX_LAST])
      |-> !tx_word[`GPT_TXW_EOI];
  endproperty
  a_eoi_only_cause: assert property (p_eoi_only_cause)
    else $error("eoi queued without a match or last byte");

  property p_eoi_on_push;
    tx_push && !active && s.cfg[`GPT_CFG_WRITE_EOI] && cfg_on && wb_sel_i[0]
      && (s.cfg[`GPT_CFG_FULL_WIDTH] ? (wb_dat_i[7:0] == s.cfg[7:0])
                                     : (wb_dat_i[6:0] == s.cfg[6:0]))
      |-> tx_word[`GPT_TXW_EOI];
  endproperty
  a_eoi_on_push: assert property (p_eoi_on_push)
    else $error("match byte queued without eoi");

  property p_no_eoi_cmd;
    tx_push && active |-> !tx_word[`GPT_TXW_EOI] && tx_word[`GPT_TXW_CMD];
  endproperty
  a_no_eoi_cmd: assert property (p_no_eoi_cmd)
    else $error("command byte queued with eoi");

  property p_last_eoi;
    tx_push && !active && s.eot && wb_sel_i[1] && wb_dat_i[`GPT_TX_LAST]
      |-> tx_word[`GPT_TXW_EOI];
  endproperty
  a_last_eoi: assert property (p_last_eoi)
    else $error("last byte queued without eoi");

  property p_read_stop;
    rx_take && !rx_atn && s.cfg[`GPT_CFG_READ_STOP]
      && (s.cfg[`GPT_CFG_FULL_WIDTH] ? (rx_data == s.cfg[7:0]) : (rx_data[6:0] == s.cfg[6:0]))
      |=> !rx_ready && s.read_done;
  endproperty
  a_read_stop: assert property (p_read_stop)
    else $error("read did not stop on match character");

  property p_end_flag;
    rx_take && !rx_atn && !rx_eoi && s.end_flag_en && s.cfg[`GPT_CFG_READ_STOP] && rx_hit
      |=> s.end_seen ##1 (s.end_seen || $past(wr_commit));
  endproperty
  a_end_flag: assert property (p_end_flag)
    else $error("end status not set on match");

  property p_ignore_char;
    rx_take && !rx_eoi && !s.cfg[`GPT_CFG_READ_STOP] && !wr_commit |=> rx_ready;
  endproperty
  a_ignore_char: assert property (p_ignore_char)
    else $error("read stopped with read-stop option clear");

  property p_standby;
    wr_commit && (wb_adr_i == `GPT_ADR_CMD) && wb_sel_i[0]
      && wb_dat_i[`GPT_CMD_GO_STANDBY] && !wb_dat_i[`GPT_CMD_TAKE_CTRL]
      |=> atn_oe_n && (ctl_state == GPT_STANDBY)
          && (hs_participate == $past(wb_dat_i[`GPT_CMD_SHADOW]));
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby request did not release atn");

  property p_spw_range;
    s.spw <= `GPT_SPW_MAX;
  endproperty
  a_spw_range: assert property (p_spw_range)
    else $error("serial poll wait code out of range");

  property p_ppoll;
    ppoll_req [*2] |-> ppoll_resp == $past(s.ist);
  endproperty
  a_ppoll: assert property (p_ppoll)
    else $error("parallel poll answer differs from ist");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// File: common/gpt_defines.svh
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// register byte offsets on the wishbone port
`define GPT_ADR_CONFIG      8'h00
`define GPT_ADR_CONTROL     8'h04
`define GPT_ADR_CMD         8'h08
`define GPT_ADR_STATUS      8'h0c
`define GPT_ADR_TXDATA      8'h10
`define GPT_ADR_RXDATA      8'h14

// termination configuration word: low byte is the match character
`define GPT_CFG_CHAR_MSB    7
`define GPT_CFG_READ_STOP   10
`define GPT_CFG_WRITE_EOI   11
`define GPT_CFG_FULL_WIDTH  12
`define GPT_CFG_RESET       16'h0000

// control register
`define GPT_CTL_EOT         0
`define GPT_CTL_END_FLAG    1
`define GPT_CTL_IST         2
`define GPT_CTL_SPW_LSB     4
`define GPT_CTL_SPW_MSB     8
`define GPT_SPW_RESET       5'h0b
`define GPT_SPW_MAX         5'h11
`define GPT_END_FLAG_RESET  1'b1

// command register, write only
`define GPT_CMD_GO_STANDBY  0
`define GPT_CMD_SHADOW      1
`define GPT_CMD_TAKE_CTRL   2
`define GPT_CMD_START_READ  3

// status register
`define GPT_ST_END          0
`define GPT_ST_READ_DONE    1
`define GPT_ST_ACTIVE       2
`define GPT_ST_SHADOW       3
`define GPT_ST_READING      4

// transmit word layout
`define GPT_TX_LAST         8
`define GPT_TXW_EOI         8
`define GPT_TXW_CMD         9
`define GPT_TXW_WIDTH       10

`endif

// File: common/gpt_pkg.sv
package gpt_pkg;

  typedef enum logic [1:0] {
    GPT_ACTIVE  = 2'b01,
    GPT_STANDBY = 2'b10
  } gpt_ctl_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] cfg;
    logic        eot;
    logic        end_flag_en;
    logic        ist;
    logic [4:0]  spw;
    gpt_ctl_t    ctl;
    logic        shadow;
    logic        reading;
    logic        end_seen;
    logic        read_done;
    logic [7:0]  rx_last;
    logic        rx_last_eoi;
    logic        ppoll_resp;
  } gpt_state_t;

endpackage

// File: hw/gpt_fifo2.sv
`timescale 1ns/1ns
`default_nettype none

module gpt_fifo2 #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           count;
  } gpt_fifo_state_t;

  gpt_fifo_state_t s;
  gpt_fifo_state_t next_s;
  logic            push;
  logic            pop;

  assign in_ready  = (s.count != CW'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && (s.wptr == AW'(i))) begin
        next_s.mem[i] = in_data;
      end
    end
    if (push) begin
      next_s.wptr = (s.wptr == AW'(DEPTH - 1)) ? '0 : AW'(s.wptr + 1'b1);
    end
    if (pop) begin
      next_s.rptr = (s.rptr == AW'(DEPTH - 1)) ? '0 : AW'(s.rptr + 1'b1);
    end
    if (push && !pop) begin
      next_s.count = CW'(s.count + 1'b1);
    end else if (pop && !push) begin
      next_s.count = CW'(s.count - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// File: verification/gpt_bus_model.sv
`timescale 1ns/1ns
`default_nettype none

// stands in for the instruments on the bus side of the byte streams
module gpt_bus_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eoi,
  input  wire logic       tx_cmd,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_eoi,
  output logic            rx_atn
);
  logic [9:0] got[$];
  logic [9:0] to_send[$];
  int         slow = 0;

  // slow 0 takes every byte, 1 stalls at random, 2 stalls until told otherwise
  always @(posedge clock) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_eoi   <= 1'b0;
      rx_atn   <= 1'b0;
    end else begin
      if (tx_valid && tx_ready)
        got.push_back({tx_cmd, tx_eoi, tx_data});
      tx_ready <= (slow == 0) || (slow == 1 && $urandom % 3 == 0);
      if (rx_valid && rx_ready)
        void'(to_send.pop_front());
      if (to_send.size() > 0) begin
        rx_valid <= 1'b1;
        {rx_atn, rx_eoi, rx_data} <= to_send[0];
      end else begin
        // no stale byte on an idle bus: the data lines keep moving
        rx_valid <= 1'b0;
        rx_atn   <= 1'b0;
        rx_eoi   <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule

`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import gpt_pkg::*;
  logic        clock, nrst, cyc, stb, we, ppoll_req;
  logic [7:0]  adr;
  logic [31:0] wdat, wb_dat_o;
  logic        wb_ack_o, tx_valid, tx_ready, tx_eoi, tx_cmd, rx_valid, rx_ready;
  logic        rx_eoi, rx_atn, atn_o, atn_oe_n, hs_participate, ppoll_resp;
  logic [7:0]  tx_data, rx_data;
  logic [4:0]  spoll_wait_code;
  gpt_ctl_t    ctl_state;
  logic [9:0]  exp_tx[$];
  int          err_total, num_checks;
  logic [3:0]  sel;
  logic [31:0] q0;

  gpt_term dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_cmd(tx_cmd),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_eoi(rx_eoi),
    .rx_atn(rx_atn), .atn_o(atn_o), .atn_oe_n(atn_oe_n),
    .hs_participate(hs_participate), .ppoll_req(ppoll_req),
    .ppoll_resp(ppoll_resp), .spoll_wait_code(spoll_wait_code),
    .ctl_state(ctl_state));

  gpt_bus_model bm (.clock(clock), .nrst(nrst), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_cmd(tx_cmd),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rx_atn(rx_atn));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run();
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // ack is sampled at the rising edge: registered outputs still show the old value there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1 && n++ < 300);
    if (n >= 300)
      err_total++;
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask

  task automatic cmd(input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, 8'h08, d, q);
    @(negedge clock);
  endtask

  function automatic logic hit(logic [15:0] cfg, logic [7:0] b);
    return cfg != 16'h0 && (cfg[12] ? b == cfg[7:0] : b[6:0] == cfg[6:0]);
  endfunction

  task automatic tx_batch(input logic [2:0] fl, input logic eot, input logic act);
    logic [15:0] cfg;
    logic [7:0]  b;
    logic [31:0] q;
    int          n;
    cfg = {3'b0, fl, 2'b0, 8'($urandom)};
    wb(1'b1, 8'h00, {16'h0, cfg}, q);
    wb(1'b1, 8'h04, {23'h0, 5'd17, 3'b001, eot}, q);
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? cfg[7:0] : (i == 1) ? cfg[7:0] ^ 8'h80 : 8'($urandom);
      exp_tx.push_back({act, !act && ((cfg[11] && hit(cfg, b)) || (eot && i == 5)), b});
      wb(1'b1, 8'h10, {23'h0, i == 5, b}, q);
    end
    for (n = 0; n < 500 && bm.got.size() < exp_tx.size(); n++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    chk("tx count", exp_tx.size(), bm.got.size());
    while (exp_tx.size() > 0 && bm.got.size() > 0)
      chk("tx word", exp_tx.pop_front(), bm.got.pop_front());
    exp_tx.delete();
    bm.got.delete();
  endtask

  task automatic rx_run(input logic [2:0] fl, input logic ef);
    logic [15:0] cfg;
    logic [7:0]  b;
    logic [9:0]  w;
    logic [31:0] q;
    int          n;
    cfg = {3'b0, fl, 2'b0, 8'($urandom)};
    wb(1'b1, 8'h00, {16'h0, cfg}, q);
    wb(1'b1, 8'h04, {30'h0, ef, 1'b0}, q);
    for (int i = 0; i < 6; i++) begin
      b = (i == 0 || i == 3) ? cfg[7:0] : (i == 1) ? cfg[7:0] ^ 8'h80 : 8'($urandom);
      w = {i == 0, i == 5, b};
      bm.to_send.push_back(w);
      if (i > 0 && (i == 5 || (fl[0] && hit(cfg, b))))
        break;
    end
    cmd(32'h8);
    n = 0;
    do wb(1'b0, 8'h0c, 32'h0, q); while (q[1] !== 1'b1 && n++ < 50);
    chk("rx status", 32'h2 | (w[8] || (hit(cfg, b) && fl[0] && ef)), q & 32'h13);
    rd(8'h14, {23'h0, w[8:0]}, "rx byte");
    chk("rx left", 0, bm.to_send.size());
    bm.to_send.delete();
    wb(1'b1, 8'h0c, 32'h3, q);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk("status clear", 32'h0, q & 32'h3);
  endtask

  initial begin
    {nrst, cyc, stb, we, ppoll_req} = 5'h0;
    adr  = 8'h00;
    wdat = 32'h0;
    sel  = 4'hf;
    err_total  = 0;
    num_checks = 0;
    void'($urandom(32'h6fa59eab));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(8'h00, 32'h0, "config");
    rd(8'h04, 32'hb2, "control");
    rd(8'h0c, 32'h0, "status");
    rd(8'h30, 32'h0, "unmapped");
    chk("spw reset", 32'd11, spoll_wait_code);
    sel <= 4'h1;
    wb(1'b1, 8'h00, 32'hffff_ff5a, q0);
    sel <= 4'hf;
    rd(8'h00, 32'h5a, "config lane");
    cmd(32'h0);
    wb(1'b1, 8'h04, 32'h110, q0);
    wb(1'b1, 8'h04, 32'h126, q0);
    rd(8'h04, 32'h116, "control spw kept");
    chk("spw", 32'd17, spoll_wait_code);
    ppoll_req <= 1'b1;
    repeat (3) @(negedge clock);
    chk("ppoll ist set", 32'h1, ppoll_resp);
    wb(1'b1, 8'h04, 32'h112, q0);
    repeat (3) @(negedge clock);
    chk("ppoll ist clear", 32'h0, ppoll_resp);
    ppoll_req <= 1'b0;
    cmd(32'h4);
    chk("ctl active", {2'b00, GPT_ACTIVE}, {atn_o, atn_oe_n, ctl_state});
    tx_batch(3'b010, 1'b1, 1'b1);
    cmd(32'h3);
    chk("standby shadow", {1'b1, GPT_STANDBY, 1'b1}, {atn_oe_n, ctl_state, hs_participate});
    cmd(32'h4);
    cmd(32'h1);
    chk("standby plain", {1'b1, GPT_STANDBY, 1'b0}, {atn_oe_n, ctl_state, hs_participate});
    // the bus side stalls so both buffer slots fill and the next write waits
    bm.slow = 2;
    fork
      tx_batch(3'b110, 1'b0, 1'b0);
      begin
        repeat (40) @(negedge clock);
        chk("tx held", 32'h1, tx_valid);
        chk("tx none taken", 32'h0, bm.got.size());
        bm.slow = 1;
      end
    join
    for (int k = 0; k < 8; k++)
      tx_batch(k[2] ? 3'b001 : k[1] ? 3'b110 : k[0] ? 3'b010 : 3'b000, k[0], 1'b0);
    for (int k = 0; k < 8; k++)
      rx_run(k[2:1] == 2'd0 ? 3'b000 : k[1] ? 3'b101 : 3'b001, k[0]);
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    complete_run();
  end
endmodule

`default_nettype wire
